// >>> include/dcf_pkg.sv
// Behaviour
// - Full flag releases promptly after a read.
// - Empty flag releases promptly after a write.
// - Almost-empty flag updates in read domain.
// - Almost-full flag updates in write domain.
// - Shared pin high at reset: second enable.
// - Shared pin low at reset: offset load.
// - Data outputs low when enabled after reset.
// - Free-running clocks accepted during reset.
// - First word appears read after empty releases.
// - First-word latency bounded at empty boundary.
// - Almost-empty asserts at empty offset n.
// - Almost-full asserts at depth minus m.
// - Almost-full threshold is depth minus m.
// - Writes ignored while full flag is low.
// - Reads ignored while empty flag is low.
// - Empty offset defaults to seven words.
// - Full offset defaults to seven words.
package dcf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 7;
  // Number of words held by the array.
  localparam logic [6:0] DEPTH = 7'h40;
  // Reset value of both flag offsets.
  localparam logic [5:0] OFFSET_DEFAULT = 6'h07;
  // Value of the data outputs after reset.
  localparam logic [8:0] DATA_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FULL_EMPTY_EDGE_SPACING_MIN_NS = 5;
  localparam int PARTIAL_FLAG_EDGE_SPACING_MIN_NS = 10;
  localparam int RESET_PULSE_WIDTH_MIN_NS = 10;
  // Least times round up to whole clock cycles.
  localparam int FULL_EMPTY_EDGE_SPACING_MIN_CYC =
    (FULL_EMPTY_EDGE_SPACING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PARTIAL_FLAG_EDGE_SPACING_MIN_CYC =
    (PARTIAL_FLAG_EDGE_SPACING_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_WIDTH_MIN_CYC =
    (RESET_PULSE_WIDTH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Role of the shared write-enable-two/load pin.
  typedef enum logic {
    DCF_ROLE_LOAD = 1'b0,
    DCF_ROLE_ENABLE = 1'b1
  } dcf_role_type;

  // Which offset register the next load access reaches.
  typedef enum logic {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL = 1'b1
  } dcf_sel_type;

  // Binary to Gray conversion of a pointer.
  function automatic logic [6:0] bin_to_gray(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray to binary conversion of a pointer.
  function automatic logic [6:0] gray_to_bin(input logic [6:0] g);
    logic [6:0] b;
    b = g;
    for (int i = 5; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// >>> include/dcf_ptr_if.sv
`timescale 1ns/1ps
// Pointers passed between the write side and the read side.
interface dcf_ptr_if;
  // Gray-coded pointers, the only values that cross sides.
  logic [6:0] wr_gray;
  logic [6:0] rd_gray;
  // Binary pointers, used locally as array addresses.
  logic [6:0] wr_bin;
  logic [6:0] rd_bin;
  modport wr_end (output wr_gray, output wr_bin, input rd_gray);
  modport rd_end (output rd_gray, output rd_bin, input wr_gray);
endinterface

// >>> rtl/dcf_write_side.sv
`timescale 1ns/1ps
// Write pointer, full flag and almost-full flag.
module dcf_write_side (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic write_req,
  input wire logic [5:0] full_offset,
  dcf_ptr_if.wr_end ptr,
  output logic full_flag_n,
  output logic almost_full_flag_n,
  output logic write_go
);

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  logic [6:0] wbin; // Binary write pointer.
  logic [6:0] rd_meta; // First synchroniser stage.
  logic [6:0] rd_sync; // Second synchroniser stage.
  logic [6:0] next_wbin;
  logic [6:0] rd_sync_bin;
  logic [6:0] next_count;
  logic next_full;
  logic next_almost_full;

  // A write only counts while the full flag is high.
  assign write_go = write_req && full_flag_n;
  assign next_wbin = wbin + {6'h00, write_go};
  assign rd_sync_bin = dcf_pkg::gray_to_bin(rd_sync);
  assign next_count = next_wbin - rd_sync_bin;
  assign next_full = next_count == dcf_pkg::DEPTH;
  // Threshold is depth less the full offset.
  assign next_almost_full = next_count >= (dcf_pkg::DEPTH - {1'b0, full_offset});
  assign ptr.wr_bin = wbin;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Flags are registered on the write clock only.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wbin <= 7'h00;
      ptr.wr_gray <= 7'h00;
      rd_meta <= 7'h00;
      rd_sync <= 7'h00;
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
    end else begin
      wbin <= next_wbin;
      ptr.wr_gray <= dcf_pkg::bin_to_gray(next_wbin);
      rd_meta <= ptr.rd_gray;
      rd_sync <= rd_meta;
      full_flag_n <= !next_full;
      almost_full_flag_n <= !next_almost_full;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_full_blocks_write: assert property (
    @(posedge clock) disable iff (!arst_n) !full_flag_n |-> !write_go)
    else $error("write accepted while full");
  chk_full_release: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!full_flag_n && rd_sync != $past(rd_sync)) |=> full_flag_n)
    else $error("full flag held after read seen");
  chk_almost_before_full: assert property (
    @(posedge clock) disable iff (!arst_n) !full_flag_n |-> !almost_full_flag_n)
    else $error("full without almost full");
  chk_gray_one_step: assert property (
    @(posedge clock) disable iff (!arst_n)
    $countones(ptr.wr_gray ^ $past(ptr.wr_gray)) <= 1)
    else $error("write gray pointer moved more than one bit");

endmodule

// >>> rtl/dcf_read_side.sv
`timescale 1ns/1ps
// Read pointer, empty flag and almost-empty flag.
module dcf_read_side (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic read_req,
  input wire logic [5:0] empty_offset,
  dcf_ptr_if.rd_end ptr,
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic read_go
);

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  logic [6:0] rbin; // Binary read pointer.
  logic [6:0] wr_meta; // First synchroniser stage.
  logic [6:0] wr_sync; // Second synchroniser stage.
  logic [6:0] next_rbin;
  logic [6:0] wr_sync_bin;
  logic [6:0] next_count;

  // A read only counts while the empty flag is high.
  assign read_go = read_req && empty_flag_n;
  assign next_rbin = rbin + {6'h00, read_go};
  assign wr_sync_bin = dcf_pkg::gray_to_bin(wr_sync);
  assign next_count = wr_sync_bin - next_rbin;
  assign ptr.rd_bin = rbin;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // A write reaches the empty flag two synchroniser edges plus one later.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rbin <= 7'h00;
      ptr.rd_gray <= 7'h00;
      wr_meta <= 7'h00;
      wr_sync <= 7'h00;
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
    end else begin
      rbin <= next_rbin;
      ptr.rd_gray <= dcf_pkg::bin_to_gray(next_rbin);
      wr_meta <= ptr.wr_gray;
      wr_sync <= wr_meta;
      empty_flag_n <= next_count != 7'h00;
      // Low while at most n words remain.
      almost_empty_flag_n <= next_count > {1'b0, empty_offset};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_empty_blocks_read: assert property (
    @(posedge clock) disable iff (!arst_n) !empty_flag_n |-> !read_go)
    else $error("read accepted while empty");
  chk_empty_release: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!empty_flag_n && wr_sync != $past(wr_sync)) |=> empty_flag_n)
    else $error("empty flag held after write seen");
  chk_almost_before_empty: assert property (
    @(posedge clock) disable iff (!arst_n) !empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");

endmodule

// >>> rtl/dcf_fifo.sv
`timescale 1ns/1ps
// 64 x 9 FIFO with programmable flag offsets and a strapped shared pin.
module dcf_fifo (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [8:0] write_data,
  input wire logic write_enable_one_n,
  input wire logic write_enable_two_or_load,
  input wire logic read_enable_one_n,
  input wire logic read_enable_two_n,
  input wire logic output_enable_n,
  output logic [8:0] data_out,
  output logic data_out_en,
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [8:0] mem [0:63]; // Data array, not reset.
  logic reset_pending; // High until the first edge after reset release.
  dcf_pkg::dcf_role_type role; // Captured role of the shared pin.
  logic [5:0] empty_offset; // Offset n.
  logic [5:0] full_offset; // Offset m.
  dcf_pkg::dcf_sel_type load_wr_sel; // Next offset to be loaded.
  dcf_pkg::dcf_sel_type load_rd_sel; // Next offset to be read back.
  logic write_go;
  logic read_go;

  dcf_ptr_if ptr ();

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Both read enables must be low for any read.
  wire read_both_n = read_enable_one_n || read_enable_two_n;
  // The shared pin low in load role steers accesses to the offsets.
  wire load_active = (role == dcf_pkg::DCF_ROLE_LOAD) && !write_enable_two_or_load;
  // A data write needs enable one low and the shared pin high in both roles.
  wire write_req = !reset_pending && !write_enable_one_n && write_enable_two_or_load;
  wire load_write = !reset_pending && load_active && !write_enable_one_n;
  wire read_req = !reset_pending && !read_both_n && !load_active;
  wire load_read = !reset_pending && load_active && !read_both_n;
  // Offset value shown during a read-back.
  wire [5:0] load_rd_value =
    (load_rd_sel == dcf_pkg::DCF_SEL_EMPTY) ? empty_offset : full_offset;

  // ----------------------------------------------------------------
  // Write and read sides
  // ----------------------------------------------------------------
  dcf_write_side u_write (
    .clock(clock),
    .arst_n(arst_n),
    .write_req(write_req),
    .full_offset(full_offset),
    .ptr(ptr.wr_end),
    .full_flag_n(full_flag_n),
    .almost_full_flag_n(almost_full_flag_n),
    .write_go(write_go)
  );

  dcf_read_side u_read (
    .clock(clock),
    .arst_n(arst_n),
    .read_req(read_req),
    .empty_offset(empty_offset),
    .ptr(ptr.rd_end),
    .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .read_go(read_go)
  );

  // ----------------------------------------------------------------
  // Data array
  // ----------------------------------------------------------------
  // Accepted writes land at the write pointer.
  always_ff @(posedge clock) begin
    if (write_go) begin
      mem[ptr.wr_bin[5:0]] <= write_data;
    end
  end

  // ----------------------------------------------------------------
  // Role strap
  // ----------------------------------------------------------------
  // Reset forces constants only; the pin level is caught on the first
  // edge after release, so clocks may run throughout reset.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_pending <= 1'b1;
      role <= dcf_pkg::DCF_ROLE_ENABLE;
    end else if (reset_pending) begin
      reset_pending <= 1'b0;
      role <= dcf_pkg::dcf_role_type'(write_enable_two_or_load);
    end
  end

  // ----------------------------------------------------------------
  // Offset registers
  // ----------------------------------------------------------------
  // Load writes fill the empty offset, then the full offset, in turn.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      empty_offset <= dcf_pkg::OFFSET_DEFAULT;
      full_offset <= dcf_pkg::OFFSET_DEFAULT;
      load_wr_sel <= dcf_pkg::DCF_SEL_EMPTY;
      load_rd_sel <= dcf_pkg::DCF_SEL_EMPTY;
    end else begin
      if (load_write) begin
        unique case (load_wr_sel)
          dcf_pkg::DCF_SEL_EMPTY: begin
            empty_offset <= write_data[5:0];
            load_wr_sel <= dcf_pkg::DCF_SEL_FULL;
          end
          dcf_pkg::DCF_SEL_FULL: begin
            full_offset <= write_data[5:0];
            load_wr_sel <= dcf_pkg::DCF_SEL_EMPTY;
          end
        endcase
      end
      if (load_read) begin
        load_rd_sel <= (load_rd_sel == dcf_pkg::DCF_SEL_EMPTY) ?
          dcf_pkg::DCF_SEL_FULL : dcf_pkg::DCF_SEL_EMPTY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output port
  // ----------------------------------------------------------------
  // Data is registered on a read; the enable follows the pin one edge late.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= dcf_pkg::DATA_RESET;
      data_out_en <= 1'b0;
    end else begin
      data_out_en <= !output_enable_n;
      if (read_go) begin
        data_out <= mem[ptr.rd_bin[5:0]];
      end else if (load_read) begin
        data_out <= {3'h0, load_rd_value};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_offset_defaults: assert property (
    @(posedge clock) disable iff (!arst_n)
    reset_pending |-> (empty_offset == 6'h07 && full_offset == 6'h07))
    else $error("offsets not at default after reset");
  chk_role_held: assert property (
    @(posedge clock) disable iff (!arst_n) !reset_pending |=> $stable(role))
    else $error("pin role changed after strap");
  chk_first_word: assert property (
    @(posedge clock) disable iff (!arst_n)
    (read_go && $past(!empty_flag_n)) |=> data_out == $past(mem[ptr.rd_bin[5:0]]))
    else $error("first word missing after empty release");
  chk_data_hold: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!read_go && !load_read) |=> $stable(data_out))
    else $error("data outputs changed without read");

endmodule

// >>> dv/dcf_consumer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Read-side consumer
// ----------------------------------------------------------------
// The consumer asks for words steadily, never, or with random stalls.
// It keeps asking while the FIFO is empty, as careless logic would.
module dcf_consumer (
  input wire logic clock,
  input wire logic [1:0] mode,
  output logic read_enable_one_n,
  output logic read_enable_two_n
);
  // Stall pattern source, with a seed of its own.
  int seed = 32'h0000_5A17;
  // Random word of the current cycle.
  logic [31:0] r;
  initial begin
    read_enable_one_n = 1'b1;
    read_enable_two_n = 1'b1;
  end
  // Requests change only on the falling edge.
  always @(negedge clock) begin
    r = $random(seed);
    case (mode)
      2'h1: begin
        read_enable_one_n = 1'b0;
        read_enable_two_n = 1'b0;
      end
      2'h2: begin
        read_enable_one_n = r[0];
        read_enable_two_n = r[1] & r[2];
      end
      default: begin
        read_enable_one_n = 1'b1;
        read_enable_two_n = 1'b1;
      end
    endcase
  end
endmodule

// >>> dv/dual_clock_fifo_flag_timing_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the FIFO with a queue model
// ----------------------------------------------------------------
module dual_clock_fifo_flag_timing_bench;
  logic clock, arst_n, we1_n, pin, oe_n, read_enable_one_n_n, read_enable_two_n_n;
  logic [8:0] write_data, data_out;
  logic data_out_en, full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n;
  logic [1:0] mode;
  int failures, total_checks;
  int seed = 32'hFD4B;
  // Model state: stored words, pointer histories and offsets.
  logic [8:0] q[$];
  int wh[$];
  int rh[$];
  int wcnt, rcnt;
  bit first, sel_w, sel_r;
  dcf_pkg::dcf_role_type role;
  logic [5:0] off_e, off_f;
  logic [8:0] e_dout;
  logic e_en, e_full, e_empty, e_af, e_ae;
  logic [5:0] offs [2] = '{6'h03, 6'h0A};

  dcf_fifo dut (.clock(clock), .arst_n(arst_n), .write_data(write_data),
    .write_enable_one_n(we1_n), .write_enable_two_or_load(pin),
    .read_enable_one_n(read_enable_one_n_n), .read_enable_two_n(read_enable_two_n_n), .output_enable_n(oe_n),
    .data_out(data_out), .data_out_en(data_out_en), .full_flag_n(full_flag_n),
    .empty_flag_n(empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n));
  dcf_consumer partner (.clock(clock), .mode(mode), .read_enable_one_n(read_enable_one_n_n),
    .read_enable_two_n(read_enable_two_n_n));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // A hang counts as a mismatch and ends the run.
  initial begin
    #200000;
    failures++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  // Flags after edge k see the remote pointer of edge k-3.
  always @(posedge clock or negedge arst_n) begin
    int ec;
    int fc;
    logic ld, wr_ok, rd_ok;
    if (!arst_n) begin
      q.delete();
      wh = '{0, 0, 0, 0};
      rh = '{0, 0, 0, 0};
      wcnt = 0;
      rcnt = 0;
      first = 1'b1;
      sel_w = 1'b0;
      sel_r = 1'b0;
      off_e = dcf_pkg::OFFSET_DEFAULT;
      off_f = dcf_pkg::OFFSET_DEFAULT;
      e_dout = dcf_pkg::DATA_RESET;
      e_en = 1'b0;
      {e_full, e_empty, e_af, e_ae} = 4'hA;
    end else begin
      ld = (role == dcf_pkg::DCF_ROLE_LOAD) && !pin && !first;
      wr_ok = !first && !we1_n && pin && e_full;
      rd_ok = !first && !read_enable_one_n_n && !read_enable_two_n_n && e_empty && !ld;
      // The strap is taken at the first edge after release.
      if (first) begin
        role = dcf_pkg::dcf_role_type'(pin);
      end
      first = 1'b0;
      e_en = !oe_n;
      if (wr_ok) begin
        q.push_back(write_data);
        wcnt++;
      end
      if (rd_ok) begin
        e_dout = q.pop_front();
        rcnt++;
      end
      if (ld && !read_enable_one_n_n && !read_enable_two_n_n) begin
        e_dout = {3'h0, sel_r ? off_f : off_e};
        sel_r = !sel_r;
      end
      wh.push_front(wcnt);
      rh.push_front(rcnt);
      void'(wh.pop_back());
      void'(rh.pop_back());
      ec = wh[3] - rcnt;
      fc = wcnt - rh[3];
      e_empty = ec > 0;
      e_ae = ec > int'(off_e);
      e_full = fc < int'(dcf_pkg::DEPTH);
      e_af = fc < int'(dcf_pkg::DEPTH) - int'(off_f);
      // A new offset takes effect from the next edge.
      if (ld && !we1_n) begin
        if (sel_w) off_f = write_data[5:0];
        else off_e = write_data[5:0];
        sel_w = !sel_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparison and verdict
  // ----------------------------------------------------------------
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Outputs are compared shortly after each falling edge, once settled.
  always @(negedge clock) begin
    #1;
    check(data_out, e_dout);
    check({8'h00, data_out_en}, {8'h00, e_en});
    check({8'h00, full_flag_n}, {8'h00, e_full});
    check({8'h00, empty_flag_n}, {8'h00, e_empty});
    check({8'h00, almost_full_flag_n}, {8'h00, e_af});
    check({8'h00, almost_empty_flag_n}, {8'h00, e_ae});
  end
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Write mode 0 idle, 1 every cycle, 2 random; reads come from the consumer.
  task automatic run(input int cycles, input int wm, input logic [1:0] rm);
    logic [31:0] r;
    mode = rm;
    repeat (cycles) begin
      @(negedge clock);
      r = $random(seed);
      write_data = r[8:0];
      we1_n = (wm == 2) ? r[9] : (wm != 1);
      if (wm == 2) oe_n = r[10];
    end
  endtask
  // The strap level is held through reset and the first edge after it.
  task automatic do_reset(input logic strap);
    @(negedge clock);
    pin = strap;
    arst_n = 1'b0;
    we1_n = 1'b1;
    mode = 2'h0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
  endtask
  // Fill past full with the consumer idle, then drain past empty.
  task automatic fill_drain;
    run(70, 1, 2'h0);
    run(75, 0, 2'h1);
  endtask

  initial begin
    {arst_n, we1_n, pin, oe_n} = 4'h6;
    write_data = 9'h000;
    mode = 2'h0;
    failures = 0;
    total_checks = 0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    run(1, 1, 2'h0);
    run(8, 0, 2'h1);
    fill_drain();
    oe_n = 1'b1;
    run(3, 0, 2'h0);
    oe_n = 1'b0;
    run(400, 2, 2'h2);
    do_reset(1'b0);
    pin = 1'b0;
    foreach (offs[i]) begin
      @(negedge clock);
      we1_n = 1'b0;
      write_data = {3'h0, offs[i]};
    end
    run(3, 0, 2'h1);
    pin = 1'b1;
    fill_drain();
    run(300, 2, 2'h2);
    close_out();
  end
endmodule
